//--- src/dac_serial_frame_mode_ctrl.sv
// Serial write port, power-down mode decode and APB status for a voltage-output DAC
//
// Operation
// - Long frame executes on the 24th falling serial clock edge with sync low.
// - Sync rising before the last edge clears the shifter and counts an abort; code and mode stay.
// - Short frame executes on the 16th falling edge; early sync release aborts.
// - Power-up code is zero, or midscale by option, until a valid write.
// - Long frame mode bits 17..16: normal, 1k, 100k, three-state.
// - Short frame mode bits 15..14 use the same four-way encoding.
// - Only mode zero is normal operation; other values power down.
// - Power-down disconnects the amplifier, attaches the 1k or 100k termination or leaves the output open, stops analog parts.
// - Every executed frame loads the DAC code, including one that selects power-down.
// - Output is valid about 5 us after leaving power-down.
// - Long frame: six ignored bits, two mode bits, sixteen data bits.
// - Short frame: two mode bits, then fourteen or twelve data bits.
// - Data is sampled on each falling serial clock edge while sync is low, up to the frame's last bit; later edges are ignored until sync rises.
`include "dac_defs.svh"
`timescale 1ns/1ns
module dac_serial_frame_mode_ctrl #(
	parameter bit MIDSCALE_RESET = 1'b0,
	parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic syncN,
	input wire logic sclk,
	input wire logic din,
	output logic [`CODE_W-1:0] dacCode,
	output dac_pkg::pd_mode_t mode,
	output logic ampOn,
	output logic pulldown1k,
	output logic pulldown100k,
	output logic outputValid
);
	import dac_pkg::*;

	localparam logic [`CODE_W-1:0] POWER_ON_CODE = MIDSCALE_RESET ? `MIDSCALE_CODE : `ZERO_CODE;

	////////////////////////////////////////////////////////////////////////////////
	// Frame field extraction

	function automatic logic [`CODE_W-1:0] frameCode(
		input logic [`SHIFT_W-1:0] s,
		input logic longFrame,
		input logic res12
	);
		logic [`CODE_W-1:0] c;
		c = s[`LONG_CODE_HI:0];
		if (!longFrame) begin
			if (res12) begin
				c = {s[`SHORT_CODE_HI:`SHORT_CODE12_LO], 4'h0};
			end else begin
				c = {s[`SHORT_CODE_HI:0], 2'b00};
			end
		end
		return c;
	endfunction

	function automatic pd_mode_t frameMode(
		input logic [`SHIFT_W-1:0] s,
		input logic longFrame
	);
		pd_mode_t m;
		if (longFrame) begin
			m = pd_mode_t'(s[`LONG_MODE_HI:`LONG_MODE_LO]);
		end else begin
			m = pd_mode_t'(s[`SHORT_MODE_HI:`SHORT_MODE_LO]);
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection

	logic [2:0] pins;
	logic syncS;
	logic sclkS;
	logic dinS;
	logic sclkPrev_q;
	logic sclkFall;

	sync_2ff #(
		.W(3)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({syncN, sclk, din}),
		.q(pins)
	);

	assign syncS = pins[2];
	assign sclkS = pins[1];
	assign dinS = pins[0];
	assign sclkFall = sclkPrev_q & ~sclkS;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclkPrev_q <= 1'b0;
		end else begin
			sclkPrev_q <= sclkS;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame state machine

	logic [`CTRL_W-1:0] ctrl_q;
	frame_state_t state_q;
	frame_state_t state_d;
	logic [`SHIFT_W-1:0] shift_q;
	logic [`SHIFT_W-1:0] shift_d;
	logic [`SHIFT_W-1:0] shiftNext;
	logic [`CNT_W-1:0] cnt_q;
	logic [`CNT_W-1:0] cnt_d;
	logic [`CNT_W-1:0] lastBit;
	logic longFrame;
	logic execute;
	logic abort;

	assign longFrame = ctrl_q[`CTRL_LONG];
	assign lastBit = (longFrame ? `LONG_FRAME_BITS : `SHORT_FRAME_BITS) - 1'b1;
	assign shiftNext = {shift_q[`SHIFT_W-2:0], dinS};

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		cnt_d = cnt_q;
		execute = 1'b0;
		abort = 1'b0;
		unique case (state_q)
			ST_HOLD: begin
				if (syncS) begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				shift_d = '0;
				cnt_d = '0;
				if (!syncS) begin
					state_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (syncS) begin
					abort = 1'b1;
					shift_d = '0;
					cnt_d = '0;
					state_d = ST_IDLE;
				end else if (sclkFall) begin
					shift_d = shiftNext;
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == lastBit) begin
						execute = 1'b1;
						cnt_d = '0;
						state_d = ST_HOLD;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_HOLD;
			shift_q <= '0;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// DAC register, mode and output stage control

	logic [`CODE_W-1:0] dacCode_q;
	pd_mode_t mode_q;
	pd_mode_t newMode;
	logic ampOn_q;
	logic pulldown1k_q;
	logic pulldown100k_q;
	logic outputValid_q;
	logic wakeStart;
	logic wakeDone;

	assign newMode = frameMode(shiftNext, longFrame);
	assign wakeStart = execute & (mode_q != MODE_NORMAL) & (newMode == MODE_NORMAL);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dacCode_q <= POWER_ON_CODE;
			mode_q <= MODE_NORMAL;
		end else if (execute) begin
			dacCode_q <= frameCode(shiftNext, longFrame, ctrl_q[`CTRL_RES12]);
			mode_q <= newMode;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ampOn_q <= 1'b1;
			pulldown1k_q <= 1'b0;
			pulldown100k_q <= 1'b0;
			outputValid_q <= 1'b1;
		end else begin
			ampOn_q <= (mode_q == MODE_NORMAL);
			pulldown1k_q <= (mode_q == MODE_PD_1K);
			pulldown100k_q <= (mode_q == MODE_PD_100K);
			outputValid_q <= (mode_q == MODE_NORMAL) & wakeDone & ~wakeStart;
		end
	end

	wake_timer #(
		.CYCLES(WAKE_CYCLES)
	) u_wake (
		.clk(clk),
		.rst(rst),
		.start(wakeStart),
		.done(wakeDone)
	);

	assign dacCode = dacCode_q;
	assign mode = mode_q;
	assign ampOn = ampOn_q;
	assign pulldown1k = pulldown1k_q;
	assign pulldown100k = pulldown100k_q;
	assign outputValid = outputValid_q;

	////////////////////////////////////////////////////////////////////////////////
	// Frame counters

	logic [`COUNT_W-1:0] execCount_q;
	logic [`COUNT_W-1:0] abortCount_q;
	logic countClear;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			execCount_q <= '0;
			abortCount_q <= '0;
		end else begin
			if (execute) begin
				execCount_q <= countClear ? `COUNT_W'(1) : execCount_q + 1'b1;
			end else if (countClear) begin
				execCount_q <= '0;
			end
			if (abort) begin
				abortCount_q <= countClear ? `COUNT_W'(1) : abortCount_q + 1'b1;
			end else if (countClear) begin
				abortCount_q <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave

	logic setup;
	logic access;
	logic hitCtrl;
	logic hitStatus;
	logic hitCount;
	logic mapped;
	logic [31:0] readMux;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	assign setup = psel & ~penable;
	assign access = psel & penable & pready_q;
	assign hitCtrl = (paddr == `REG_CTRL);
	assign hitStatus = (paddr == `REG_STATUS);
	assign hitCount = (paddr == `REG_COUNT);
	assign mapped = hitCtrl | hitStatus | hitCount;
	assign countClear = access & pwrite & hitCount;

	always_comb begin
		readMux = '0;
		if (hitCtrl) begin
			readMux[`CTRL_W-1:0] = ctrl_q;
		end else if (hitStatus) begin
			readMux[`CODE_W-1:0] = dacCode_q;
			readMux[`STAT_MODE_HI:`STAT_MODE_LO] = mode_q;
			readMux[`STAT_VALID] = outputValid_q;
			readMux[`STAT_BUSY] = (state_q == ST_SHIFT);
		end else if (hitCount) begin
			readMux[`COUNT_W-1:0] = execCount_q;
			readMux[`COUNT_ABORT_LO +: `COUNT_W] = abortCount_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q <= (setup & ~pwrite) ? readMux : '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `CTRL_RESET;
		end else if (access & pwrite & hitCtrl) begin
			ctrl_q <= pwdata[`CTRL_W-1:0];
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

endmodule

//--- src/dac_defs.svh
// Numeric constants for the serial DAC frame and mode controller
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

// Frame geometry
`define LONG_FRAME_BITS 5'd24
`define SHORT_FRAME_BITS 5'd16
`define SHIFT_W 24
`define CNT_W 5
`define CODE_W 16
`define LONG_MODE_HI 17
`define LONG_MODE_LO 16
`define LONG_CODE_HI 15
`define SHORT_MODE_HI 15
`define SHORT_MODE_LO 14
`define SHORT_CODE_HI 13
`define SHORT_CODE12_LO 2

// Power-on codes, left justified
`define ZERO_CODE 16'h0000
`define MIDSCALE_CODE 16'h8000

// Wake-up time from power-down
`define WAKE_TIME_NS 5000
`define CLK_PERIOD_NS 50
`define WAKE_CYCLES ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_W 8

// APB register map
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_COUNT 12'h008

// Control register fields
`define CTRL_W 2
`define CTRL_LONG 0
`define CTRL_RES12 1
`define CTRL_RESET 2'h1

// Status register fields
`define STAT_MODE_LO 16
`define STAT_MODE_HI 17
`define STAT_VALID 18
`define STAT_BUSY 19

// Frame counter register fields
`define COUNT_W 16
`define COUNT_ABORT_LO 16

`endif

//--- src/dac_pkg.sv
// Types shared by the serial DAC frame and mode controller
package dac_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_HOLD = 3'b100
	} frame_state_t;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_PD_1K = 2'b01,
		MODE_PD_100K = 2'b10,
		MODE_TRISTATE = 2'b11
	} pd_mode_t;

endpackage

//--- src/sync_2ff.sv
// Two-flop synchroniser for a group of independent pin levels
`timescale 1ns/1ns
module sync_2ff #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

//--- src/wake_timer.sv
// Counts the settling time after the output leaves power-down
`include "dac_defs.svh"
`timescale 1ns/1ns
module wake_timer #(
	parameter int CYCLES = `WAKE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	output logic done
);

	localparam logic [`WAKE_W-1:0] LOAD = `WAKE_W'(CYCLES - 1);

	logic [`WAKE_W-1:0] cnt_q;
	logic busy_q;

	assign done = ~busy_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else if (start) begin
			cnt_q <= LOAD;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 1'b1;
			busy_q <= (cnt_q != '0);
		end
	end

endmodule

//--- sim/dac_serial_frame_mode_ctrl_checker.sv
// Port assertions for the serial DAC controller
`timescale 1ns/1ns
`include "dac_defs.svh"
module dac_serial_frame_mode_ctrl_checker import dac_pkg::*; #(
	parameter int WAKE_CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic syncN,
	input wire logic [`CODE_W-1:0] dacCode,
	input wire dac_pkg::pd_mode_t mode,
	input wire logic ampOn,
	input wire logic pulldown1k,
	input wire logic pulldown100k,
	input wire logic outputValid
);
	localparam int WAKE_MAX = WAKE_CYCLES + 4;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready too long");
	a_err_unmapped: assert property (pready |->
		pslverr == !(paddr inside {`REG_CTRL, `REG_STATUS, `REG_COUNT}))
		else $error("pslverr wrong");
	a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("prdata not zero");
	a_amp_follow: assert property (ampOn == ($past(mode) == MODE_NORMAL))
		else $error("ampOn wrong");
	a_pd_network: assert property ((pulldown1k == ($past(mode) == MODE_PD_1K)) &&
		(pulldown100k == ($past(mode) == MODE_PD_100K)))
		else $error("termination wrong");
	a_valid_normal: assert property (outputValid |-> ampOn)
		else $error("valid in power-down");
	a_wake_delay: assert property (mode == MODE_NORMAL && $past(mode) != MODE_NORMAL
		|-> !outputValid [*3] ##[0:WAKE_MAX] outputValid)
		else $error("wake time wrong");
	a_load_cause: assert property ($changed(dacCode) || $changed(mode)
		|-> !$past(syncN, 3) || !$past(syncN, 4) || !$past(syncN, 5))
		else $error("load without frame");
	cover property ($rose(pulldown1k));
	cover property (mode == MODE_TRISTATE);
	cover property (pready && pslverr);
endmodule
bind dac_serial_frame_mode_ctrl dac_serial_frame_mode_ctrl_checker #(.WAKE_CYCLES(WAKE_CYCLES)) chk (
	.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .syncN(syncN), .dacCode(dacCode),
	.mode(mode), .ampOn(ampOn), .pulldown1k(pulldown1k), .pulldown100k(pulldown100k),
	.outputValid(outputValid));

//--- sim/serial_master.sv
// Serial frame master driving the sync, clock and data pins
`timescale 1ns/1ns
module serial_master (
	input wire logic clk,
	output logic syncN,
	output logic sclk,
	output logic din
);
	initial begin
		syncN = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Sends k bits of an n-bit word; bits past n are filler
	task automatic send(input logic [23:0] w, input int n, input int k, input bit gaps);
		@(posedge clk);
		syncN <= 1'b0;
		waitClk(4);
		for (int i = 0; i < k; i++) begin
			if (gaps && i > 0 && i % 8 == 0) waitClk(12);
			din <= (i < n) ? w[n-1-i] : ~w[0];
			sclk <= 1'b1;
			waitClk(4);
			sclk <= 1'b0;
			waitClk(4);
		end
		syncN <= 1'b1;
		din <= ~din;
		waitClk(4);
	endtask
endmodule

//--- sim/tb_dac_serial_frame_mode_ctrl.sv
// Self-checking bench for the serial DAC controller
`timescale 1ns/1ns
`include "dac_defs.svh"
module tb_dac_serial_frame_mode_ctrl;
	import dac_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [`ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, syncN, sclk, din, ampOn, pulldown1k, pulldown100k, outputValid;
	logic [`CODE_W-1:0] dacCode;
	pd_mode_t mode;
	int nMismatch = 0;
	int totalChecks = 0;
	always #25 clk = ~clk;
	serial_master link (.clk(clk), .syncN(syncN), .sclk(sclk), .din(din));
	dac_serial_frame_mode_ctrl #(.MIDSCALE_RESET(1'b0), .WAKE_CYCLES(40)) DUT (
		.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .syncN(syncN),
		.sclk(sclk), .din(din), .dacCode(dacCode), .mode(mode), .ampOn(ampOn),
		.pulldown1k(pulldown1k), .pulldown100k(pulldown100k), .outputValid(outputValid));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic [11:0] a, input bit wr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int t = 0;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Request holds until pready is sampled high at a rising edge
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (t >= 20) nMismatch++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic apbw(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(a, 1'b1, d, rd, e);
	endtask
	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp,
		input logic experr);
		logic [31:0] rd;
		logic e;
		apb(a, 1'b0, 32'h0, rd, e);
		chk(what, rd, exp);
		chk("pslverr", e, experr);
	endtask
	task automatic outs(input logic [15:0] c, input pd_mode_t m);
		chk("dacCode", dacCode, c);
		chk("mode", mode, m);
		chk("stage", {ampOn, pulldown1k, pulldown100k},
			{m == MODE_NORMAL, m == MODE_PD_1K, m == MODE_PD_100K});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic tReset();
		outs(16'h0000, MODE_NORMAL);
		rdchk("ctrl", `REG_CTRL, 32'h1, 1'b0);
		rdchk("status", `REG_STATUS, 32'h0004_0000, 1'b0);
		rdchk("unmapped", 12'h00c, 32'h0, 1'b1);
	endtask
	task automatic tLongModes();
		logic [15:0] c;
		for (int m = 3; m >= 0; m--) begin
			c = {4{m[3:0]}} ^ 16'ha5c3;
			link.send({6'h2a, m[1:0], c}, 24, 24, 1'b0);
			outs(c, pd_mode_t'(m[1:0]));
		end
	endtask
	task automatic tWake();
		int t = 0;
		link.send({8'h01, 16'h4321}, 24, 24, 1'b0);
		rdchk("status", `REG_STATUS, 32'h0001_4321, 1'b0);
		link.send({8'h00, 16'h4321}, 24, 24, 1'b0);
		chk("outputValid", outputValid, 1'b0);
		while (outputValid !== 1'b1 && t < 100) begin
			@(negedge clk);
			t++;
		end
		chk("outputValid", outputValid, 1'b1);
	endtask
	task automatic tAbort();
		link.send({8'h01, 16'hdead}, 24, 23, 1'b0);
		outs(16'h4321, MODE_NORMAL);
		link.send({8'h00, 16'h0f0f}, 24, 32, 1'b1);
		outs(16'h0f0f, MODE_NORMAL);
		rdchk("count", `REG_COUNT, 32'h0001_0007, 1'b0);
		apbw(`REG_COUNT, 32'h0);
		rdchk("count", `REG_COUNT, 32'h0, 1'b0);
	endtask
	task automatic tShort();
		apbw(`REG_CTRL, 32'h0);
		link.send({8'h0, 2'b10, 14'h1234}, 16, 16, 1'b0);
		outs({14'h1234, 2'b00}, MODE_PD_100K);
		link.send({8'h0, 2'b11, 14'h3fff}, 16, 15, 1'b0);
		outs({14'h1234, 2'b00}, MODE_PD_100K);
		apbw(`REG_CTRL, 32'h2);
		link.send({8'h0, 2'b00, 12'habc, 2'b11}, 16, 16, 1'b0);
		outs({12'habc, 4'h0}, MODE_NORMAL);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		tReset();
		tLongModes();
		tWake();
		tAbort();
		tShort();
		tallyAndFinish();
	end
	initial begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		tallyAndFinish();
	end
endmodule
